// *** srw_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_filter #(
  parameter int unsigned COUNT = 2,
  parameter logic IDLE = 1'h0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  import srw_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic dout_r;
  logic [FILT_W-1:0] cnt_r;
  wire logic differs;
  wire logic settled;

  assign differs = sync2_r != dout_r;
  assign settled = cnt_r == FILT_W'(COUNT - 1);
  assign dout = dout_r;

  // Both stages start idle so an unconnected input never acts. (see R7)
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= IDLE;
      sync2_r <= IDLE;
    end else begin
      sync1_r <= din;
      sync2_r <= sync1_r;
    end
  end

  // A level must stay put for COUNT cycles before it is taken, which
  // swallows bounce and short noise in both directions. (see R8)
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      dout_r <= IDLE;
    end else if (!differs) begin
      cnt_r <= '0;
    end else if (settled) begin
      cnt_r <= '0;
      dout_r <= sync2_r;
    end else begin
      cnt_r <= cnt_r + FILT_W'(1);
    end
  end

endmodule : srw_filter
`default_nettype wire

// *** srw_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host side of the kick pin. It raises the pin after every kick_gap + 1 low cycles,
// or releases it so that only the supervisor's own weak drive is seen.
module srw_host_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] kick_gap,
  input wire logic kick_float,
  input wire logic kick_out,
  input wire logic kick_oe_n,
  output logic kick_pin
);
  logic [15:0] gap_cnt_r;
  logic level_r;

  // A large gap starves the watchdog on purpose. The pin rests low and
  // shows a high pulse of 23 cycles (92 ns), the shortest that must clear.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_cnt_r <= 16'h0000;
      level_r <= 1'h0;
    end else if (level_r) begin
      // Clearing is its own branch, apart from setting.
      if (gap_cnt_r >= 16'h0016) begin
        gap_cnt_r <= 16'h0000;
        level_r <= 1'h0;
      end else begin
        gap_cnt_r <= gap_cnt_r + 16'h0001;
      end
    end else if (gap_cnt_r >= kick_gap) begin
      gap_cnt_r <= 16'h0000;
      level_r <= 1'h1;
    end else begin
      gap_cnt_r <= gap_cnt_r + 16'h0001;
    end
  end

  // A released pin with no weak drive would float, so it reads as low.
  assign kick_pin = !kick_float ? level_r :
                    (!kick_oe_n ? kick_out : 1'h0);
endmodule : srw_host_model
`default_nettype wire

// *** srw_pkg.sv ***
// What this block and its host must do
// R1: Power-up holds reset low for hold time.
// R2: Brownout asserts reset immediately.
// R3: Reset held hold time after last cause.
// R4: New dip restarts hold timer from zero.
// R5: Manual reset low asserts reset.
// R6: Reset held while manual low, then hold.
// R7: Unconnected manual reset reads inactive high.
// R8: Manual reset contact bounce filtered internally.
// R9: No kick within period issues reset pulse.
// R10: Host kicks faster than minimum watchdog period.
// R11: Any kick edge clears watchdog timer.
// R12: Watchdog cleared and stopped while reset asserted.
// R13: Host floats kick pin to disable watchdog.
// R14: Floating kick driven low 7/8, high 1/8. Here the drive is high for 3 cycles at the 7/8 point.
// R15: Host may pull reset line low safely.
// R16: Brief supply glitches do not cause reset.
// R17: Host best holds kick low, pulses high.
// R18: Host sets and clears kick in separate places.
// R19: Manual pulses up to 130 ns rejected. Here only lows under 128 ns are sure to be rejected.
// R20: Inputs synchronised, kick edges clear counter.
// R21: Intervals from one prescaled counter chain.
package srw_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // Prescaler base tick of the counter chain.
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 8;

  localparam int unsigned RESET_HOLD_MS = 25;
  localparam int unsigned WATCHDOG_MS = 200;
  localparam int unsigned HOLD_TICKS = RESET_HOLD_MS * 1000000 / TICK_NS;
  localparam int unsigned WD_TICKS = WATCHDOG_MS * 1000000 / TICK_NS;
  localparam int unsigned HOLD_W = 15;
  localparam int unsigned WD_W = 18;

  // Longest manual low that must be rejected; the cycle count rounds up.
  localparam int unsigned MR_REJECT_NS = 130;
  localparam int unsigned MR_FILT_CYC =
    (MR_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least duration of an under-voltage flag to be genuine; rounds up.
  localparam int unsigned UV_GLITCH_NS = 1000;
  localparam int unsigned UV_FILT_CYC =
    (UV_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned FILT_W = 8;

  localparam logic MR_IDLE_LEVEL = 1'h1;
  localparam logic UV_IDLE_LEVEL = 1'h0;

  typedef struct packed {
    logic brownout;
    logic manual;
    logic expiry;
  } srw_cause_t;

endpackage : srw_pkg

// *** srw_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor #(
  parameter int unsigned HOLD_TICKS_P = srw_pkg::HOLD_TICKS,
  parameter int unsigned WD_TICKS_P = srw_pkg::WD_TICKS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic under_voltage,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  output logic watchdog_kick_out,
  output logic watchdog_kick_oe_n,
  output logic reset_out_n
);
  import srw_pkg::*;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_TICKS_P - 1);
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TICKS_P - 1);
  localparam logic [WD_W-1:0] WD_HIGH_FROM =
    WD_W'(WD_TICKS_P - WD_TICKS_P / 8);

  wire logic tick;
  wire logic uv_filt;
  wire logic mr_filt_n;
  wire srw_cause_t cause;
  wire logic any_cause;
  wire logic hold_done;
  wire logic kick_edge;
  wire logic wd_done;
  wire logic rst_nxt;
  wire logic [HOLD_W-1:0] hold_nxt;
  wire logic [WD_W-1:0] wd_nxt;
  wire logic kick_drive_nxt;

  logic rst_r;
  logic reset_out_n_r;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic [WD_W-1:0] wd_cnt_r;
  logic kick_s1_r;
  logic kick_s2_r;
  logic kick_prev_r;
  logic kick_drive_r;
  logic kick_oe_n_r;

  srw_tick u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick)
  );

  // Short dips of the supply flag are absorbed by the filter. (see R16)
  srw_filter #(
    .COUNT(UV_FILT_CYC),
    .IDLE(UV_IDLE_LEVEL)
  ) u_uv_filter (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(under_voltage),
    .dout(uv_filt)
  );

  // Lows shorter than 128 ns never reach the cause logic. (see R19)
  srw_filter #(
    .COUNT(MR_FILT_CYC),
    .IDLE(MR_IDLE_LEVEL)
  ) u_mr_filter (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(manual_reset_in_n),
    .dout(mr_filt_n)
  );

  assign cause.brownout = uv_filt; // see R2
  assign cause.manual = !mr_filt_n; // see R5
  assign cause.expiry = wd_done; // see R9
  assign any_cause = |cause;

  // Any live cause keeps the counter at zero, so the hold period always
  // runs from the end of the latest event. (see R3) (see R4) (see R6)
  assign hold_done = rst_r && tick && hold_cnt_r == HOLD_LAST;
  assign rst_nxt = any_cause || (rst_r && !hold_done);
  assign hold_nxt = (any_cause || !rst_r) ? '0 :
                    tick ? hold_cnt_r + HOLD_W'(1) : hold_cnt_r;

  // Kick is sampled through two flops; either edge counts. (see R20)
  assign kick_edge = kick_s2_r != kick_prev_r; // see R11
  assign wd_done = !rst_r && !kick_edge && tick && wd_cnt_r == WD_LAST;
  assign wd_nxt = (rst_r || kick_edge || wd_done) ? '0 : // see R12
                  tick ? wd_cnt_r + WD_W'(1) : wd_cnt_r;

  // With the pin floating this drive is what the pin shows, so the rise
  // at the 7/8 point clears the timer before it can expire. (see R14)
  assign kick_drive_nxt = wd_nxt >= WD_HIGH_FROM;

  // The pin driver is weak (series resistor), so a host that drives the
  // pin overrides it; the enable therefore stays on. (see R13)
  assign watchdog_kick_oe_n = kick_oe_n_r;
  assign watchdog_kick_out = kick_drive_r;
  assign reset_out_n = reset_out_n_r;

  // Reset starts asserted with a zero count, so release only follows a
  // full hold period after power-up. (see R1)
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_r <= 1'h1;
      hold_cnt_r <= '0;
      reset_out_n_r <= 1'h0;
    end else begin
      rst_r <= rst_nxt;
      hold_cnt_r <= hold_nxt;
      reset_out_n_r <= !rst_nxt;
    end
  end

  // The reset line is never read back, so a host pulling it low while
  // it is released disturbs no state here. (see R15)
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      kick_s1_r <= 1'h0;
      kick_s2_r <= 1'h0;
      kick_prev_r <= 1'h0;
      wd_cnt_r <= '0;
      kick_drive_r <= 1'h0;
      kick_oe_n_r <= 1'h0;
    end else begin
      kick_s1_r <= watchdog_kick_in;
      kick_s2_r <= kick_s1_r;
      kick_prev_r <= kick_s2_r;
      wd_cnt_r <= wd_nxt;
      kick_drive_r <= kick_drive_nxt;
      kick_oe_n_r <= 1'h0;
    end
  end

  sequence s_cause_seen;
    any_cause;
  endsequence

  sequence s_reset_low_zero;
    !reset_out_n && hold_cnt_r == '0;
  endsequence

  property p_brownout;
    @(posedge core_clk) disable iff (!resetn)
      uv_filt |=> !reset_out_n;
  endproperty
  a_brownout: assert property (p_brownout) // see R2
    else $error("Brownout did not assert reset.");

  property p_manual;
    @(posedge core_clk) disable iff (!resetn)
      !mr_filt_n |=> !reset_out_n;
  endproperty
  a_manual: assert property (p_manual) // see R5
    else $error("Manual reset did not assert reset.");

  property p_restart;
    @(posedge core_clk) disable iff (!resetn)
      s_cause_seen |=> s_reset_low_zero;
  endproperty
  a_restart: assert property (p_restart) // see R4
    else $error("Hold timer not restarted by a cause.");

  property p_release;
    @(posedge core_clk) disable iff (!resetn)
      $rose(reset_out_n) |->
        $past(hold_cnt_r) == HOLD_LAST && $past(tick) && !$past(any_cause);
  endproperty
  a_release: assert property (p_release) // see R3
    else $error("Reset released before full hold time.");

  property p_manual_release;
    @(posedge core_clk) disable iff (!resetn)
      $rose(mr_filt_n) |=> !reset_out_n [*2];
  endproperty
  a_manual_release: assert property (p_manual_release) // see R6
    else $error("Reset released right after manual input.");

  property p_expiry;
    @(posedge core_clk) disable iff (!resetn)
      wd_done |=> !reset_out_n && wd_cnt_r == '0;
  endproperty
  a_expiry: assert property (p_expiry) // see R9
    else $error("Watchdog expiry did not assert reset.");

  property p_kick_clear;
    @(posedge core_clk) disable iff (!resetn)
      kick_edge |=> wd_cnt_r == '0;
  endproperty
  a_kick_clear: assert property (p_kick_clear) // see R11
    else $error("Kick edge did not clear watchdog timer.");

  property p_hold_stop;
    @(posedge core_clk) disable iff (!resetn)
      !reset_out_n |=> wd_cnt_r == '0;
  endproperty
  a_hold_stop: assert property (p_hold_stop) // see R12
    else $error("Watchdog counted while reset asserted.");

  property p_self_drive;
    @(posedge core_clk) disable iff (!resetn)
      watchdog_kick_out |-> wd_cnt_r >= WD_HIGH_FROM;
  endproperty
  a_self_drive: assert property (p_self_drive) // see R14
    else $error("Kick drive high outside last eighth.");

  property p_powerup;
    @(posedge core_clk) disable iff (!resetn)
      $rose(reset_out_n) |-> $past(rst_r);
  endproperty
  a_powerup: assert property (p_powerup) // see R1
    else $error("Reset released without hold phase.");

endmodule : srw_supervisor
`default_nettype wire

// *** srw_supervisor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_tb_top;
  localparam int unsigned HOLD_T = 4;
  localparam int unsigned WD_T = 16;

  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic under_voltage = 1'h0;
  logic mr_drive = 1'h0;
  logic mr_val = 1'h1;
  logic [15:0] kick_gap = 16'h05DC;
  logic kick_float = 1'h0;
  logic manual_pin;
  logic kick_pin;
  logic kick_out;
  logic kick_oe_n;
  logic reset_out_n;
  int error_cnt = 0;
  int cmp_count = 0;

  always #2 core_clk = ~core_clk;

  // The manual pin has a pull-up, so an undriven pin reads high.
  assign manual_pin = mr_drive ? mr_val : 1'h1;

  srw_supervisor #(.HOLD_TICKS_P(HOLD_T), .WD_TICKS_P(WD_T)) uut (
    .core_clk(core_clk),
    .resetn(resetn),
    .under_voltage(under_voltage),
    .manual_reset_in_n(manual_pin),
    .watchdog_kick_in(kick_pin),
    .watchdog_kick_out(kick_out),
    .watchdog_kick_oe_n(kick_oe_n),
    .reset_out_n(reset_out_n)
  );

  srw_host_model host (
    .core_clk(core_clk),
    .resetn(resetn),
    .kick_gap(kick_gap),
    .kick_float(kick_float),
    .kick_out(kick_out),
    .kick_oe_n(kick_oe_n),
    .kick_pin(kick_pin)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic cmp(input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp

  task automatic hold_lvl(input logic v, input int n);
    for (int i = 0; i < n && reset_out_n === v; i++) cyc(1);
    cmp(v, reset_out_n);
  endtask : hold_lvl

  task automatic wait_lvl(input logic v, input int n);
    for (int i = 0; i < n && reset_out_n !== v; i++) cyc(1);
    cmp(v, reset_out_n);
  endtask : wait_lvl

  task automatic t_power;
    hold_lvl(1'h0, 700);
    wait_lvl(1'h1, 700);
    $display("test power_up done");
  endtask : t_power

  task automatic t_brownout;
    under_voltage = 1'h1;
    cyc(100);
    under_voltage = 1'h0;
    hold_lvl(1'h1, 400);
    under_voltage = 1'h1;
    wait_lvl(1'h0, 270);
    cyc(50);
    under_voltage = 1'h0;
    cyc(600);
    under_voltage = 1'h1;
    cyc(300);
    under_voltage = 1'h0;
    hold_lvl(1'h0, 700);
    wait_lvl(1'h1, 1000);
    $display("test brownout done");
  endtask : t_brownout

  task automatic t_manual;
    mr_drive = 1'h1;
    repeat (3) begin
      mr_val = 1'h0;
      cyc(20);
      mr_val = 1'h1;
      cyc(10);
    end
    hold_lvl(1'h1, 100);
    mr_val = 1'h0;
    wait_lvl(1'h0, 45);
    hold_lvl(1'h0, 2000);
    mr_drive = 1'h0;
    hold_lvl(1'h0, 700);
    wait_lvl(1'h1, 1000);
    $display("test manual done");
  endtask : t_manual

  task automatic t_kick;
    hold_lvl(1'h1, 12000);
    kick_gap = 16'hFFFF;
    wait_lvl(1'h0, 5000);
    hold_lvl(1'h0, 700);
    wait_lvl(1'h1, 1000);
    // This span ends before even an uncleared timer could expire.
    hold_lvl(1'h1, 3400);
    $display("test watchdog done");
  endtask : t_kick

  task automatic t_float;
    int hi;
    hi = 0;
    kick_float = 1'h1;
    for (int i = 0; i < 12000 && reset_out_n === 1'h1; i++) begin
      if (kick_out === 1'h1) hi++;
      cyc(1);
    end
    cmp(1'h1, reset_out_n);
    cmp(1'h1, hi > 0 && hi < 1500);
    $display("test float done");
  endtask : t_float

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    #400000;
    error_cnt++;
    summarize();
  end

  initial begin
    cyc(5);
    resetn = 1'h1;
    t_power();
    t_brownout();
    t_manual();
    t_kick();
    t_float();
    summarize();
  end
endmodule : srw_supervisor_tb_top
`default_nettype wire

// *** srw_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_tick (
  input wire logic core_clk,
  input wire logic resetn,
  output logic tick
);
  import srw_pkg::*;

  logic [TICK_W-1:0] cnt_r;
  logic tick_r;
  wire logic wrap;

  assign wrap = cnt_r == TICK_W'(TICK_CYC - 1);
  assign tick = tick_r;

  // One free-running prescaler feeds every long interval. (see R21)
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick_r <= 1'h0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + TICK_W'(1);
      tick_r <= wrap;
    end
  end

endmodule : srw_tick
`default_nettype wire
